// file: common/dmf_defs.svh
// Register offsets, field widths and timing counts for the drive monitor bank.
// Included by the package and the design; holds definitions only.
`ifndef DMF_DEFS_SVH
`define DMF_DEFS_SVH
// Register word offsets on the plain register port.
`define DMF_OFF_REFERENCE_SPEED 8'h00
`define DMF_OFF_AVERAGE_LOAD_RATE 8'h01
`define DMF_OFF_ENCODER_POSITION_DEVIATION 8'h02
`define DMF_OFF_FEEDBACK_PULSE_COUNT 8'h03
`define DMF_OFF_POWER_ON_TIME 8'h04
`define DMF_OFF_PHASE_CURRENT_RMS 8'h05
`define DMF_OFF_BUS_VOLTAGE 8'h06
`define DMF_OFF_POWER_MODULE_TEMPERATURE 8'h07
`define DMF_OFF_LIVE_INPUT_STATUS 8'h08
`define DMF_OFF_FAULT_HISTORY_SELECT 8'h09
`define DMF_OFF_FAULT_CODE 8'h0A
`define DMF_OFF_FAULT_TIME_STAMP 8'h0B
`define DMF_OFF_FAULT_MOTOR_SPEED 8'h0C
`define DMF_OFF_FAULT_PHASE_U_CURRENT 8'h0D
`define DMF_OFF_FAULT_PHASE_V_CURRENT 8'h0E
`define DMF_OFF_FAULT_BUS_VOLTAGE 8'h0F
`define DMF_OFF_FAULT_INPUT_SNAPSHOT 8'h10
`define DMF_OFF_IRQ_STATUS 8'h11
`define DMF_OFF_IRQ_MASK 8'h12
// Fault history geometry.
`define DMF_HIST_DEPTH 10
`define DMF_SEL_MAX 16'h0009
`define DMF_NUM_INPUTS 5
// Interrupt status bits.
`define DMF_IRQ_FAULT_BIT 0
`define DMF_IRQ_OVERWRITE_BIT 1
`define DMF_IRQ_WIDTH 2
// Timing: clock rate and power-on counter step.
`define DMF_CLK_HZ 200000000
`define DMF_POT_STEP_MS 100
`define DMF_POT_STEP_CYCLES ((`DMF_CLK_HZ / 1000) * `DMF_POT_STEP_MS)
// Seconds tick for the operating time used as fault time stamp.
`define DMF_SEC_CYCLES `DMF_CLK_HZ
`endif

// file: common/dmf_pkg.sv
// Types shared by the drive monitor bank.
// Assumes dmf_defs.svh is on the include path.
`include "dmf_defs.svh"
package dmf_pkg;
  // One captured fault record.
  typedef struct packed {
    logic [15:0] code;
    logic [31:0] time_stamp;
    logic [15:0] speed;
    logic [15:0] cur_u;
    logic [15:0] cur_v;
    logic [15:0] bus_v;
    logic [`DMF_NUM_INPUTS-1:0] inputs;
  } dmf_record_s;
  // Live measurements presented by the drive core.
  typedef struct packed {
    logic [15:0] reference_speed;
    logic [15:0] average_load_rate;
    logic [15:0] phase_current_rms;
    logic [15:0] bus_voltage;
    logic [15:0] module_temperature;
    logic [15:0] phase_u_current;
    logic [15:0] phase_v_current;
    logic [15:0] motor_speed;
  } dmf_live_s;
  // Register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dmf_req_s;
endpackage

// file: hw/dmf_monitor.sv
// Drive monitoring register bank with a ten-deep fault history.
// Assumes live measurements and pulse strobes are synchronous to sys_clk_in.
`timescale 1ns/1ps
`include "dmf_defs.svh"
module dmf_monitor (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Register port.
  input wire dmf_pkg::dmf_req_s req_in,
  output logic [31:0] rdata_out,
  // Live measurements from the drive core.
  input wire dmf_pkg::dmf_live_s live_in,
  input wire logic [`DMF_NUM_INPUTS-1:0] digital_input_in,
  // Position tracking strobes.
  input wire logic ref_pulse_in,
  input wire logic ref_dir_in,
  input wire logic fb_pulse_in,
  input wire logic fb_dir_in,
  input wire logic abs_mode_in,
  input wire logic [31:0] abs_pos_low_in,
  // Fault event.
  input wire logic fault_in,
  input wire logic [15:0] fault_code_in,
  // Interrupt.
  output logic irq_out
);
  // Divider terminal counts, widened to the counter width.
  localparam int DEPTH = `DMF_HIST_DEPTH;
  localparam logic [31:0] POT_CYC = 32'(`DMF_POT_STEP_CYCLES);
  localparam logic [31:0] SEC_CYC = 32'(`DMF_SEC_CYCLES);

  // Records, counters and interrupt state.
  dmf_pkg::dmf_record_s hist_r [DEPTH];
  logic [3:0] hist_count_r;
  logic [15:0] sel_r;
  logic [31:0] deviation_r;
  logic [31:0] fb_count_r;
  logic [31:0] pot_r;
  logic [31:0] pot_div_r;
  logic [31:0] op_sec_r;
  logic [31:0] sec_div_r;
  logic [`DMF_IRQ_WIDTH-1:0] irq_stat_r;
  logic [`DMF_IRQ_WIDTH-1:0] irq_mask_r;
  logic [`DMF_IRQ_WIDTH-1:0] irq_set;
  logic [31:0] rdata_nxt;
  dmf_pkg::dmf_record_s sel_rec;
  dmf_pkg::dmf_record_s cap_rec;

  // Register write decode, used by several processes.
  function automatic logic wr_hit(input dmf_pkg::dmf_req_s r, input logic [7:0] off);
    wr_hit = r.wr && (r.addr == off);
  endfunction

  // Signed step of a direction-qualified pulse.
  function automatic logic [31:0] step(input logic pulse, input logic dir);
    if (!pulse) begin
      step = 32'h0000_0000;
    end else if (dir) begin
      step = 32'hFFFF_FFFF;
    end else begin
      step = 32'h0000_0001;
    end
  endfunction

  // Deviation counts references up and feedback down, wrapping as signed 32 bits.
  // A reference and a feedback strobe in one cycle are summed, cancelling when their directions match, so simultaneous pulses lose nothing.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      deviation_r <= 32'h0000_0000;
    end else begin
      deviation_r <= deviation_r + step(ref_pulse_in, ref_dir_in) - step(fb_pulse_in, fb_dir_in);
    end
  end

  // Feedback counter; an absolute encoder overrides with its low position word.
  // Relative strobes are not counted while the absolute word is followed; only its low half is visible.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fb_count_r <= 32'h0000_0000;
    end else if (abs_mode_in) begin
      fb_count_r <= abs_pos_low_in;
    end else begin
      fb_count_r <= fb_count_r + step(fb_pulse_in, fb_dir_in);
    end
  end

  // Power-on time in 0.1 s steps; the counter wraps after about 13 years.
  // The divider runs from reset release, so the first step lands one full period later.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pot_div_r <= 32'h0000_0000;
      pot_r <= 32'h0000_0000;
    end else if (pot_div_r == POT_CYC - 32'h0000_0001) begin
      pot_div_r <= 32'h0000_0000;
      pot_r <= pot_r + 32'h0000_0001;
    end else begin
      pot_div_r <= pot_div_r + 32'h0000_0001;
    end
  end

  // Whole operating seconds, kept apart so the stamp needs no division.
  // Part of a second is dropped, so a stamp can lag the true fault time by up to one second.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sec_div_r <= 32'h0000_0000;
      op_sec_r <= 32'h0000_0000;
    end else if (sec_div_r == SEC_CYC - 32'h0000_0001) begin
      sec_div_r <= 32'h0000_0000;
      op_sec_r <= op_sec_r + 32'h0000_0001;
    end else begin
      sec_div_r <= sec_div_r + 32'h0000_0001;
    end
  end

  // Capture of the drive state at the fault instant.
  // Bus voltage is truncated to whole volts; rounding would cost an adder for no visible gain.
  always_comb begin
    cap_rec.code = fault_code_in;
    cap_rec.time_stamp = op_sec_r;
    cap_rec.speed = live_in.motor_speed;
    cap_rec.cur_u = live_in.phase_u_current;
    cap_rec.cur_v = live_in.phase_v_current;
    cap_rec.bus_v = 16'(live_in.bus_voltage / 16'h000A);
    cap_rec.inputs = digital_input_in;
  end

  // History shift register; empty slots hold zero so unused records read zero.
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_hist
      if (i == 0) begin : g_head
        // The newest slot takes the capture.
        always_ff @(posedge sys_clk_in or posedge rst_in) begin
          if (rst_in) begin
            hist_r[i] <= '0;
          end else if (fault_in) begin
            hist_r[i] <= cap_rec;
          end
        end
      end else begin : g_tail
        // Older slots take their younger neighbour, so the last record falls off the end.
        always_ff @(posedge sys_clk_in or posedge rst_in) begin
          if (rst_in) begin
            hist_r[i] <= '0;
          end else if (fault_in) begin
            hist_r[i] <= hist_r[i-1];
          end
        end
      end
    end
  endgenerate

  // Count of logged faults, saturating at the history depth.
  // It only serves the overwrite flag, so it never needs to count past a full history.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hist_count_r <= 4'h0;
    end else if (fault_in && hist_count_r != 4'(DEPTH)) begin
      hist_count_r <= hist_count_r + 4'h1;
    end
  end

  // Selector ignores out-of-range writes so it always names a valid record.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_r <= 16'h0000;
    end else if (wr_hit(req_in, `DMF_OFF_FAULT_HISTORY_SELECT) && req_in.wdata[15:0] <= `DMF_SEL_MAX) begin
      sel_r <= req_in.wdata[15:0];
    end
  end

  assign sel_rec = hist_r[sel_r[3:0]];

  // Interrupt events: a new fault, and a fault that pushed out a full history.
  always_comb begin
    irq_set = '0;
    irq_set[`DMF_IRQ_FAULT_BIT] = fault_in;
    irq_set[`DMF_IRQ_OVERWRITE_BIT] = fault_in && (hist_count_r == 4'(DEPTH));
  end

  // Sticky status, write one to clear; a same-cycle event wins over the clear.
  // Reading the status never disturbs it, so software may poll freely.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_r <= '0;
    end else if (wr_hit(req_in, `DMF_OFF_IRQ_STATUS)) begin
      irq_stat_r <= (irq_stat_r & ~req_in.wdata[`DMF_IRQ_WIDTH-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  // Interrupt mask, all sources masked after reset.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_mask_r <= '0;
    end else if (wr_hit(req_in, `DMF_OFF_IRQ_MASK)) begin
      irq_mask_r <= req_in.wdata[`DMF_IRQ_WIDTH-1:0];
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  // Read multiplexer; unmapped offsets read zero.
  // Fault fields follow the selector as it stands in the strobe cycle.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (req_in.addr)
      `DMF_OFF_REFERENCE_SPEED: rdata_nxt = {16'h0000, live_in.reference_speed};
      `DMF_OFF_AVERAGE_LOAD_RATE: rdata_nxt = {16'h0000, live_in.average_load_rate};
      `DMF_OFF_ENCODER_POSITION_DEVIATION: rdata_nxt = deviation_r;
      `DMF_OFF_FEEDBACK_PULSE_COUNT: rdata_nxt = fb_count_r;
      `DMF_OFF_POWER_ON_TIME: rdata_nxt = pot_r;
      `DMF_OFF_PHASE_CURRENT_RMS: rdata_nxt = {16'h0000, live_in.phase_current_rms};
      `DMF_OFF_BUS_VOLTAGE: rdata_nxt = {16'h0000, live_in.bus_voltage};
      `DMF_OFF_POWER_MODULE_TEMPERATURE: rdata_nxt = {16'h0000, live_in.module_temperature};
      `DMF_OFF_LIVE_INPUT_STATUS: rdata_nxt = {27'h0, digital_input_in};
      `DMF_OFF_FAULT_HISTORY_SELECT: rdata_nxt = {16'h0000, sel_r};
      `DMF_OFF_FAULT_CODE: rdata_nxt = {16'h0000, sel_rec.code};
      `DMF_OFF_FAULT_TIME_STAMP: rdata_nxt = sel_rec.time_stamp;
      `DMF_OFF_FAULT_MOTOR_SPEED: rdata_nxt = {16'h0000, sel_rec.speed};
      `DMF_OFF_FAULT_PHASE_U_CURRENT: rdata_nxt = {16'h0000, sel_rec.cur_u};
      `DMF_OFF_FAULT_PHASE_V_CURRENT: rdata_nxt = {16'h0000, sel_rec.cur_v};
      `DMF_OFF_FAULT_BUS_VOLTAGE: rdata_nxt = {16'h0000, sel_rec.bus_v};
      `DMF_OFF_FAULT_INPUT_SNAPSHOT: rdata_nxt = {27'h0, sel_rec.inputs};
      `DMF_OFF_IRQ_STATUS: rdata_nxt = {30'h0, irq_stat_r};
      `DMF_OFF_IRQ_MASK: rdata_nxt = {30'h0, irq_mask_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (req_in.rd) begin
      rdata_out <= rdata_nxt;
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  // Assertions on the history, the counters, the read path and the interrupt.
  // Selector and history records.
  a_sel_range: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sel_r <= `DMF_SEL_MAX)
    else $error("selector out of range");
  a_sel_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.wr && req_in.addr == `DMF_OFF_FAULT_HISTORY_SELECT && req_in.wdata[15:0] <= `DMF_SEL_MAX
    |=> sel_r == $past(req_in.wdata[15:0]))
    else $error("selector write lost");
  a_sel_refused: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.wr && req_in.addr == `DMF_OFF_FAULT_HISTORY_SELECT && req_in.wdata[15:0] > `DMF_SEL_MAX
    |=> $stable(sel_r))
    else $error("out-of-range selector taken");
  a_hist_shift: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fault_in |=> hist_r[1] == $past(hist_r[0]) && hist_r[9] == $past(hist_r[8]))
    else $error("history not shifted");
  a_hist_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !fault_in |=> $stable(hist_r[0]) && $stable(hist_r[9]))
    else $error("history moved without fault");
  a_count_sat: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    hist_count_r <= 4'(DEPTH))
    else $error("fault count past depth");
  a_hist_capture: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fault_in |=> hist_r[0].code == $past(fault_code_in))
    else $error("fault code not captured");
  a_speed_capture: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fault_in |=> hist_r[0].speed == $past(live_in.motor_speed))
    else $error("fault speed not captured");
  a_cur_u_capture: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fault_in |=> hist_r[0].cur_u == $past(live_in.phase_u_current))
    else $error("phase U current not captured");
  a_cur_v_capture: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fault_in |=> hist_r[0].cur_v == $past(live_in.phase_v_current))
    else $error("phase V current not captured");
  a_busv_capture: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fault_in |=> hist_r[0].bus_v == $past(live_in.bus_voltage) / 16'h000A)
    else $error("fault bus voltage not captured");
  a_inputs_capture: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fault_in |=> hist_r[0].inputs == $past(digital_input_in))
    else $error("input snapshot wrong");
  a_stamp_capture: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fault_in |=> hist_r[0].time_stamp == $past(op_sec_r))
    else $error("time stamp wrong");
  a_empty_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    hist_count_r == 4'h0 |-> sel_rec == '0)
    else $error("empty history not zero");

  // Position and time counters.
  a_dev_track: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ref_pulse_in && !ref_dir_in && !fb_pulse_in |=> deviation_r == $past(deviation_r) + 32'h0000_0001)
    else $error("deviation not incremented");
  a_dev_fb: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fb_pulse_in && !fb_dir_in && !ref_pulse_in |=> deviation_r == $past(deviation_r) - 32'h0000_0001)
    else $error("deviation not decremented");
  a_fb_abs: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    abs_mode_in |=> fb_count_r == $past(abs_pos_low_in))
    else $error("absolute position not followed");
  a_fb_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !abs_mode_in && fb_pulse_in && !fb_dir_in |=> fb_count_r == $past(fb_count_r) + 32'h0000_0001)
    else $error("feedback pulse not counted");
  a_pot_step: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pot_div_r == POT_CYC - 32'h0000_0001 |=> pot_r == $past(pot_r) + 32'h0000_0001 && pot_div_r == 32'h0)
    else $error("power-on time not advanced");
  a_pot_div: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pot_div_r != POT_CYC - 32'h0000_0001 |=> pot_div_r == $past(pot_div_r) + 32'h0000_0001 && $stable(pot_r))
    else $error("power-on divider wrong");
  a_sec_div: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sec_div_r != SEC_CYC - 32'h0000_0001 |=> sec_div_r == $past(sec_div_r) + 32'h0000_0001 && $stable(op_sec_r))
    else $error("seconds divider wrong");

  // Read path: data one cycle after the strobe, zero otherwise.
  a_rd_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !req_in.rd |=> rdata_out == 32'h0000_0000)
    else $error("read data without strobe");
  a_rd_next: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.rd && req_in.addr == `DMF_OFF_LIVE_INPUT_STATUS |=> rdata_out[4:0] == $past(digital_input_in))
    else $error("input status read wrong");
  a_rd_ref_speed: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.rd && req_in.addr == `DMF_OFF_REFERENCE_SPEED |=> rdata_out == {16'h0000, $past(live_in.reference_speed)})
    else $error("reference speed read wrong");
  a_rd_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.rd && req_in.addr == `DMF_OFF_AVERAGE_LOAD_RATE |=> rdata_out == {16'h0000, $past(live_in.average_load_rate)})
    else $error("load rate read wrong");
  a_rd_phase: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.rd && req_in.addr == `DMF_OFF_PHASE_CURRENT_RMS |=> rdata_out == {16'h0000, $past(live_in.phase_current_rms)})
    else $error("phase current read wrong");
  a_rd_bus: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.rd && req_in.addr == `DMF_OFF_BUS_VOLTAGE |=> rdata_out == {16'h0000, $past(live_in.bus_voltage)})
    else $error("bus voltage read wrong");
  a_rd_temp: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.rd && req_in.addr == `DMF_OFF_POWER_MODULE_TEMPERATURE |=> rdata_out[15:0] == $past(live_in.module_temperature))
    else $error("temperature read wrong");
  a_rd_code: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.rd && req_in.addr == `DMF_OFF_FAULT_CODE |=> rdata_out == {16'h0000, $past(sel_rec.code)})
    else $error("fault code read wrong");
  a_rd_stamp: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.rd && req_in.addr == `DMF_OFF_FAULT_TIME_STAMP |=> rdata_out == $past(sel_rec.time_stamp))
    else $error("time stamp read wrong");
  a_rd_snapshot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.rd && req_in.addr == `DMF_OFF_FAULT_INPUT_SNAPSHOT |=> rdata_out == {27'h0, $past(sel_rec.inputs)})
    else $error("input snapshot read wrong");

  // Interrupt status: events always land, and a clear only drops bits that had no event.
  a_irq_set_wins: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_set != '0 |=> (irq_stat_r & $past(irq_set)) == $past(irq_set))
    else $error("interrupt event lost");
  a_irq_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.wr && req_in.addr == `DMF_OFF_IRQ_STATUS && irq_set == '0
    |=> (irq_stat_r & $past(req_in.wdata[`DMF_IRQ_WIDTH-1:0])) == '0)
    else $error("status bit not cleared");
  a_mask_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.wr && req_in.addr == `DMF_OFF_IRQ_MASK |=> irq_mask_r == $past(req_in.wdata[`DMF_IRQ_WIDTH-1:0]))
    else $error("mask write lost");

  // Main scenarios.
  c_fault: cover property (@(posedge sys_clk_in) disable iff (rst_in) fault_in);
  c_full: cover property (@(posedge sys_clk_in) disable iff (rst_in) irq_set[`DMF_IRQ_OVERWRITE_BIT]);
  c_sel9: cover property (@(posedge sys_clk_in) disable iff (rst_in) sel_r == `DMF_SEL_MAX && sel_rec != '0);
  c_irq: cover property (@(posedge sys_clk_in) disable iff (rst_in) irq_out);
  c_sel_refused: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.wr && req_in.addr == `DMF_OFF_FAULT_HISTORY_SELECT && req_in.wdata[15:0] > `DMF_SEL_MAX);
endmodule

// file: tb/dmf_monitor_tb.sv
// Self-checking bench for the drive monitor bank: live fields, position counters, fault history and interrupt.
// Assumes dmf_defs.svh and dmf_pkg are compiled first; all stimulus changes just after a rising edge.
`timescale 1ns/1ps
`include "dmf_defs.svh"
module dmf_monitor_tb;
  // Design inputs, all given a value at time zero.
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  dmf_pkg::dmf_req_s req_in = '0;
  logic [31:0] rdata_out;
  dmf_pkg::dmf_live_s live_in = '0;
  logic [`DMF_NUM_INPUTS-1:0] digital_input_in = '0;
  logic ref_pulse_in = 1'b0;
  logic ref_dir_in = 1'b0;
  logic fb_pulse_in = 1'b0;
  logic fb_dir_in = 1'b0;
  logic abs_mode_in = 1'b0;
  logic [31:0] abs_pos_low_in = 32'h0;
  logic fault_in = 1'b0;
  logic [15:0] fault_code_in = 16'h0;
  logic irq_out;
  int err_total = 0;
  int n_compared = 0;

  // Clock of 200 MHz.
  always #2.5 sys_clk_in = ~sys_clk_in;

  dmf_monitor i_dmf_monitor (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_in(req_in), .rdata_out(rdata_out), .live_in(live_in),
    .digital_input_in(digital_input_in), .ref_pulse_in(ref_pulse_in), .ref_dir_in(ref_dir_in),
    .fb_pulse_in(fb_pulse_in), .fb_dir_in(fb_dir_in), .abs_mode_in(abs_mode_in),
    .abs_pos_low_in(abs_pos_low_in), .fault_in(fault_in), .fault_code_in(fault_code_in), .irq_out(irq_out)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares a settled value with its expectation; case inequality keeps unknowns from matching.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %0h, wanted %0h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    req_in.addr <= a;
    req_in.wdata <= d;
    req_in.wr <= 1'b1;
    @(posedge sys_clk_in);
    req_in.wr <= 1'b0;
  endtask

  // One-cycle read strobe; the data stand only in the following cycle, so they are sampled there.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    req_in.addr <= a;
    req_in.rd <= 1'b1;
    @(posedge sys_clk_in);
    req_in.rd <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask

  // Single position strobe; sel picks reference (1) or feedback (0).
  task automatic pulse(input logic sel, input logic dir);
    @(posedge sys_clk_in);
    ref_pulse_in <= sel;
    ref_dir_in <= dir;
    fb_pulse_in <= ~sel;
    fb_dir_in <= dir;
    @(posedge sys_clk_in);
    ref_pulse_in <= 1'b0;
    fb_pulse_in <= 1'b0;
  endtask

  // Watchdog: the whole sequence needs a few hundred cycles.
  initial begin
    #200000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end

  // Main sequence.
  initial begin
    int k;
    int s;
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    // Empty history reads zero in every field, and nothing has been powered long enough to count.
    for (int a = 8'h0A; a <= 8'h10; a++) begin
      rd(a[7:0], 32'h0);
    end
    rd(`DMF_OFF_POWER_ON_TIME, 32'h0);
    // Live fields pass through in the low half, inputs keep bit n-1 for input n.
    @(posedge sys_clk_in);
    live_in.reference_speed <= 16'hF448;
    live_in.average_load_rate <= 16'h03E8;
    live_in.phase_current_rms <= 16'h002E;
    live_in.bus_voltage <= 16'h0C26;
    live_in.module_temperature <= 16'h001B;
    digital_input_in <= 5'h1E;
    rd(`DMF_OFF_REFERENCE_SPEED, 32'h0000F448);
    rd(`DMF_OFF_AVERAGE_LOAD_RATE, 32'h000003E8);
    rd(`DMF_OFF_PHASE_CURRENT_RMS, 32'h0000002E);
    rd(`DMF_OFF_BUS_VOLTAGE, 32'h00000C26);
    rd(`DMF_OFF_POWER_MODULE_TEMPERATURE, 32'h0000001B);
    rd(`DMF_OFF_LIVE_INPUT_STATUS, 32'h0000001E);
    // Three references forward, one feedback forward then two backward: deviation 3 - (-1).
    repeat (3) pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b0);
    rd(`DMF_OFF_FEEDBACK_PULSE_COUNT, 32'h1);
    rd(`DMF_OFF_ENCODER_POSITION_DEVIATION, 32'h2);
    repeat (2) pulse(1'b0, 1'b1);
    rd(`DMF_OFF_FEEDBACK_PULSE_COUNT, 32'hFFFFFFFF);
    rd(`DMF_OFF_ENCODER_POSITION_DEVIATION, 32'h4);
    pulse(1'b1, 1'b1);
    rd(`DMF_OFF_ENCODER_POSITION_DEVIATION, 32'h3);
    @(posedge sys_clk_in);
    abs_pos_low_in <= 32'h89ABCDEF;
    abs_mode_in <= 1'b1;
    rd(`DMF_OFF_FEEDBACK_PULSE_COUNT, 32'h89ABCDEF);
    // Eleven faults back to back with the fault interrupt unmasked; the first one is dropped.
    wr(`DMF_OFF_IRQ_MASK, 32'h1);
    rd(`DMF_OFF_IRQ_MASK, 32'h1);
    for (k = 0; k <= 10; k++) begin
      @(posedge sys_clk_in);
      live_in.motor_speed <= 16'hF000 + k[15:0];
      live_in.phase_u_current <= 16'h0040 + k[15:0];
      live_in.phase_v_current <= 16'h0050 + k[15:0];
      live_in.bus_voltage <= 16'd3110 + 16'(k * 10) + 16'd7;
      digital_input_in <= k[4:0];
      fault_code_in <= 16'h0100 + k[15:0];
      @(posedge sys_clk_in);
      fault_in <= 1'b1;
      @(posedge sys_clk_in);
      fault_in <= 1'b0;
      #1;
      if (k == 0) begin
        chk({31'h0, irq_out}, 32'h1);
        wr(`DMF_OFF_IRQ_STATUS, 32'h1);
        #1;
        chk({31'h0, irq_out}, 32'h0);
      end
      if (k == 9) begin
        rd(`DMF_OFF_IRQ_STATUS, 32'h1);
      end
    end
    rd(`DMF_OFF_IRQ_STATUS, 32'h3);
    chk({31'h0, irq_out}, 32'h1);
    wr(`DMF_OFF_IRQ_MASK, 32'h0);
    #1;
    chk({31'h0, irq_out}, 32'h0);
    // Walk every selector value; record s holds fault 10 - s, bus voltage in whole volts.
    for (s = 0; s <= 9; s++) begin
      k = 10 - s;
      wr(`DMF_OFF_FAULT_HISTORY_SELECT, s);
      rd(`DMF_OFF_FAULT_CODE, 32'h0100 + k);
      rd(`DMF_OFF_FAULT_TIME_STAMP, 32'h0);
      rd(`DMF_OFF_FAULT_MOTOR_SPEED, 32'hF000 + k);
      rd(`DMF_OFF_FAULT_PHASE_U_CURRENT, 32'h0040 + k);
      rd(`DMF_OFF_FAULT_PHASE_V_CURRENT, 32'h0050 + k);
      rd(`DMF_OFF_FAULT_BUS_VOLTAGE, 32'd311 + k);
      rd(`DMF_OFF_FAULT_INPUT_SNAPSHOT, k);
    end
    // Out-of-range selector, read-only field and unmapped offset are all refused.
    wr(`DMF_OFF_FAULT_HISTORY_SELECT, 32'h3);
    wr(`DMF_OFF_FAULT_HISTORY_SELECT, 32'hA);
    rd(`DMF_OFF_FAULT_HISTORY_SELECT, 32'h3);
    wr(`DMF_OFF_FAULT_CODE, 32'hFFFF);
    rd(`DMF_OFF_FAULT_CODE, 32'h0107);
    rd(8'h20, 32'h0);
    // A reset in mid-run empties the history and returns selector, counters and status to zero.
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(`DMF_OFF_FAULT_HISTORY_SELECT, 32'h0);
    rd(`DMF_OFF_FAULT_CODE, 32'h0);
    rd(`DMF_OFF_FAULT_BUS_VOLTAGE, 32'h0);
    rd(`DMF_OFF_ENCODER_POSITION_DEVIATION, 32'h0);
    rd(`DMF_OFF_IRQ_STATUS, 32'h0);
    results();
  end
endmodule
